// ---- verilog/usb_irq_map.svh ----
// Register offsets, field positions and reset values of the USB device event flags
`ifndef USB_IRQ_MAP_SVH
`define USB_IRQ_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define USB_IRQ_FLAGS_ADDR 8'hC4
`define USB_IRQ_MASK_ADDR 8'hC5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define USB_IRQ_FLAGS_RESET 8'h00
`define USB_IRQ_MASK_RESET 8'h00
`define USB_IRQ_RDATA_RESET 8'h00

// ----------------------------------------------------------------
// Field positions, shared by flags and enable mask
// ----------------------------------------------------------------
`define USB_IRQ_BIT_FRAME_START 0
`define USB_IRQ_BIT_SETUP 1
`define USB_IRQ_BIT_STATUS 2
`define USB_IRQ_BIT_SUSPEND_END 3
`define USB_IRQ_BIT_SUSPEND_BEGIN 4
`define USB_IRQ_BIT_DETACH 5
`define USB_IRQ_BIT_ATTACH 6
`define USB_IRQ_BIT_SINGLE_ENDED_ZERO 7

`endif

// ---- verilog/usb_irq_pkg.sv ----
// Types shared by the USB device event flag block
`default_nettype none

package usb_irq_pkg;

    typedef logic [7:0] sfrByte_t;
    typedef logic [7:0] sfrAddr_t;

endpackage

`default_nettype wire

// ---- verilog/usb_device_interrupt_flags.sv ----
// USB device event flags, per-event enable mask and device interrupt request
//
// Function
// (RULE_01) Interrupt only when event enable, general device enable and global enable set.
// (RULE_02) Every event type has its own enable bit, independent of the others.
// (RULE_03) Setup enable set lets a setup event interrupt; clear suppresses it.
// (RULE_04) Frame-start enable set lets a frame-start event interrupt; clear suppresses it.
// (RULE_05) Reading the request flag register clears all flags after the read; an event set in the read cycle stays set.
// (RULE_06) Flag register at C4, reset 00, bits SE0, attach, detach, susp, resume, status, setup, SOF.
// (RULE_07) Suspend-end flag is set by hardware whenever suspend mode is left.
// (RULE_08) Setup flag is set after a setup packet passed on to the CPU.
// (RULE_09) Flags set regardless of enables; request is OR of set and enabled flags.
`include "usb_irq_map.svh"
`default_nettype none

module usb_device_interrupt_flags (
    input wire logic mclk,
    input wire logic reset_n,
    input wire usb_irq_pkg::sfrAddr_t sfrAddr,
    input wire logic sfrRdEn,
    input wire logic sfrWrEn,
    input wire usb_irq_pkg::sfrByte_t sfrWrData,
    output usb_irq_pkg::sfrByte_t sfrRdData,
    input wire logic [7:0] eventSet,
    input wire logic generalDeviceIrqEnable,
    input wire logic globalIrqEnable,
    output logic deviceIrq
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    usb_irq_pkg::sfrByte_t flags_ff;
    usb_irq_pkg::sfrByte_t nxt_flags;
    usb_irq_pkg::sfrByte_t mask_ff;
    usb_irq_pkg::sfrByte_t nxt_mask;
    usb_irq_pkg::sfrByte_t rdData_ff;
    usb_irq_pkg::sfrByte_t nxt_rdData;
    logic irq_ff;
    logic nxt_irq;
    logic flagsRead;
    logic maskRead;
    logic maskWrite;
    logic pendingEnabled;

    // ----------------------------------------------------------------
    // Register decode
    // ----------------------------------------------------------------
    // The flag byte has no write decode, so a write aimed at it is dropped
    assign flagsRead = sfrRdEn && (sfrAddr == `USB_IRQ_FLAGS_ADDR);
    assign maskRead = sfrRdEn && (sfrAddr == `USB_IRQ_MASK_ADDR);
    assign maskWrite = sfrWrEn && (sfrAddr == `USB_IRQ_MASK_ADDR);

    // At least one flag that is both pending and enabled
    assign pendingEnabled = |(flags_ff & mask_ff); // RULE_09

    // ----------------------------------------------------------------
    // Enable mask
    // ----------------------------------------------------------------
    // Bit positions follow the flag byte, so one AND gives the enabled requests
    always_comb begin
        nxt_mask = mask_ff;
        if (maskWrite) begin
            nxt_mask = sfrWrData; // RULE_02
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mask_ff <= `USB_IRQ_MASK_RESET;
        end else begin
            mask_ff <= nxt_mask;
        end
    end

    // ----------------------------------------------------------------
    // Request flags
    // ----------------------------------------------------------------
    // An event in the clearing cycle survives: it was not in the byte just read,
    // so letting the clear win would lose it for good
    always_comb begin
        nxt_flags = flags_ff;
        if (flagsRead) begin
            nxt_flags = 8'h00; // RULE_05
        end
        nxt_flags = nxt_flags | eventSet; // RULE_07 RULE_08 RULE_09
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            flags_ff <= `USB_IRQ_FLAGS_RESET; // RULE_06
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    // Zero outside a read, so a stale byte cannot be taken for fresh data
    always_comb begin
        nxt_rdData = 8'h00;
        if (sfrRdEn) begin
            case (sfrAddr)
                `USB_IRQ_FLAGS_ADDR: begin
                    nxt_rdData = flags_ff; // RULE_06
                end
                `USB_IRQ_MASK_ADDR: begin
                    nxt_rdData = mask_ff; // RULE_02
                end
                default: begin
                    nxt_rdData = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdData_ff <= `USB_IRQ_RDATA_RESET;
        end else begin
            rdData_ff <= nxt_rdData;
        end
    end

    // ----------------------------------------------------------------
    // Device interrupt request
    // ----------------------------------------------------------------
    // Registered so the request is glitch free; it lags flags and enables by one cycle
    always_comb begin
        nxt_irq = pendingEnabled && generalDeviceIrqEnable
            && globalIrqEnable; // RULE_01 RULE_03 RULE_04 RULE_09
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign sfrRdData = rdData_ff;
    assign deviceIrq = irq_ff;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    sequence seqFlagRead;
        flagsRead && (eventSet == 8'h00);
    endsequence

    sequence seqIrqCause;
        pendingEnabled && generalDeviceIrqEnable && globalIrqEnable;
    endsequence

    sequence seqFlagsQuiet;
        !flagsRead && (eventSet == 8'h00);
    endsequence

    sequence seqEventUnmasked;
        (eventSet != 8'h00) && (mask_ff == 8'h00) && !maskWrite;
    endsequence

    AST_IRQ_NEEDS_ENABLES: assert property ( // RULE_01
        deviceIrq |-> $past(generalDeviceIrqEnable) && $past(globalIrqEnable))
        else $error("Interrupt raised without both general and global enables");

    AST_IRQ_RAISED: assert property (seqIrqCause |=> deviceIrq) // RULE_01
        else $error("Enabled pending flag did not raise the interrupt");

    AST_IRQ_GEN_OFF: assert property ( // RULE_01
        !generalDeviceIrqEnable |=> !deviceIrq)
        else $error("Interrupt raised while the general device enable was clear");

    AST_IRQ_ONLY_ENABLED: assert property ( // RULE_09
        deviceIrq |-> $past(pendingEnabled))
        else $error("Interrupt raised with no flag both set and enabled");

    AST_MASK_WRITE: assert property ( // RULE_02
        maskWrite |=> mask_ff == $past(sfrWrData))
        else $error("Enable mask did not take the written byte");

    AST_MASK_READ: assert property ( // RULE_02
        maskRead |=> sfrRdData == $past(mask_ff))
        else $error("Enable mask read returned wrong byte");

    AST_SETUP_MASKED: assert property ( // RULE_03
        (flags_ff == 8'h02) && !mask_ff[`USB_IRQ_BIT_SETUP] |=> !deviceIrq)
        else $error("Masked setup flag raised the interrupt");

    AST_FRAME_MASKED: assert property ( // RULE_04
        (flags_ff == 8'h01) && !mask_ff[`USB_IRQ_BIT_FRAME_START] |=> !deviceIrq)
        else $error("Masked frame-start flag raised the interrupt");

    AST_READ_CLEARS: assert property (seqFlagRead |=> flags_ff == 8'h00) // RULE_05
        else $error("Flag register not cleared after read");

    AST_READ_SET_WINS: assert property ( // RULE_05
        flagsRead |=> flags_ff == $past(eventSet))
        else $error("Read clear lost an event of the same cycle");

    AST_FLAGS_HOLD: assert property (seqFlagsQuiet |=> $stable(flags_ff)) // RULE_05
        else $error("Flags changed without an event or a read");

    AST_READ_DATA: assert property ( // RULE_06
        flagsRead |=> sfrRdData == $past(flags_ff))
        else $error("Flag register read returned wrong byte");

    AST_RDATA_IDLE: assert property ( // RULE_06
        !sfrRdEn |=> sfrRdData == 8'h00)
        else $error("Read data not zero outside a read");

    AST_SUSPEND_END_SET: assert property ( // RULE_07
        eventSet[`USB_IRQ_BIT_SUSPEND_END] |=> flags_ff[`USB_IRQ_BIT_SUSPEND_END])
        else $error("Suspend-end event lost");

    AST_SETUP_SET: assert property ( // RULE_08
        eventSet[`USB_IRQ_BIT_SETUP] |=> flags_ff[`USB_IRQ_BIT_SETUP])
        else $error("Setup event lost");

    AST_FRAME_SET: assert property ( // RULE_09
        eventSet[`USB_IRQ_BIT_FRAME_START] |=> flags_ff[`USB_IRQ_BIT_FRAME_START])
        else $error("Frame-start event lost");

    AST_SET_UNMASKED: assert property ( // RULE_09
        seqEventUnmasked |=>
        ((flags_ff & $past(eventSet)) == $past(eventSet)) ##1 !deviceIrq)
        else $error("Event not flagged while its enable was clear");

endmodule

`default_nettype wire

// ---- verif/cpu_sfr_model.sv ----
// CPU side model that drives the SFR strobes of the event flag block
`default_nettype none

module cpu_sfr_model (
    input wire logic mclk,
    output var usb_irq_pkg::sfrAddr_t sfrAddr,
    output var logic sfrRdEn,
    output var logic sfrWrEn,
    output var usb_irq_pkg::sfrByte_t sfrWrData
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        sfrAddr = 8'h00;
        sfrRdEn = 1'b0;
        sfrWrEn = 1'b0;
        sfrWrData = 8'h00;
    end

    // Idle lines show inverted values so a stale address cannot pass for a real one
    task automatic access(input logic write, input usb_irq_pkg::sfrAddr_t a,
                          input usb_irq_pkg::sfrByte_t d);
        @(negedge mclk);
        sfrAddr = a;
        sfrWrData = d;
        sfrWrEn = write;
        sfrRdEn = ~write;
        @(negedge mclk);
        sfrWrEn = 1'b0;
        sfrRdEn = 1'b0;
        sfrAddr = ~a;
        sfrWrData = ~d;
    endtask
endmodule

`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the USB device event flag block
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [7:0] ev; logic [7:0] mask; logic gen; logic glob; logic irq;} row_s;
    logic mclk, reset_n, sfrRdEn, sfrWrEn, generalDeviceIrqEnable, globalIrqEnable, deviceIrq;
    usb_irq_pkg::sfrAddr_t sfrAddr;
    usb_irq_pkg::sfrByte_t sfrWrData, sfrRdData;
    logic [7:0] eventSet;
    int failures = 0;
    int samplesChecked = 0;
    row_s rows[10] = '{'{8'h02, 8'h02, 1'b1, 1'b1, 1'b1}, '{8'h02, 8'hFD, 1'b1, 1'b1, 1'b0},
        '{8'h01, 8'h01, 1'b1, 1'b1, 1'b1}, '{8'h01, 8'hFE, 1'b1, 1'b1, 1'b0},
        '{8'h80, 8'h80, 1'b0, 1'b1, 1'b0}, '{8'h80, 8'h80, 1'b1, 1'b0, 1'b0},
        '{8'h08, 8'h08, 1'b1, 1'b1, 1'b1}, '{8'h04, 8'h00, 1'b1, 1'b1, 1'b0},
        '{8'h30, 8'h10, 1'b1, 1'b1, 1'b1}, '{8'h40, 8'h20, 1'b1, 1'b1, 1'b0}};

    usb_device_interrupt_flags i_usb_device_interrupt_flags (.mclk(mclk), .reset_n(reset_n),
        .sfrAddr(sfrAddr), .sfrRdEn(sfrRdEn), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData),
        .sfrRdData(sfrRdData), .eventSet(eventSet), .deviceIrq(deviceIrq),
        .generalDeviceIrqEnable(generalDeviceIrqEnable), .globalIrqEnable(globalIrqEnable));
    cpu_sfr_model i_cpu_sfr_model (.mclk(mclk), .sfrAddr(sfrAddr), .sfrRdEn(sfrRdEn),
        .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samplesChecked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd(input usb_irq_pkg::sfrAddr_t a);
        i_cpu_sfr_model.access(1'b0, a, 8'h00);
    endtask

    task automatic wrap_up();
        if (failures == 0 && samplesChecked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // A full run is about 130 cycles; the 5000-cycle limit leaves wide margin
    initial begin
        #100000;
        failures++;
        wrap_up();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        reset_n = 1'b0;
        eventSet = 8'h00;
        generalDeviceIrqEnable = 1'b0;
        globalIrqEnable = 1'b0;
        repeat (20) @(negedge mclk);
        reset_n = 1'b1;
        rd(8'hC4);
        chk("flags reset", 8'h00, sfrRdData);
        foreach (rows[i]) begin
            i_cpu_sfr_model.access(1'b1, 8'hC5, rows[i].mask);
            generalDeviceIrqEnable = rows[i].gen;
            globalIrqEnable = rows[i].glob;
            eventSet = rows[i].ev;
            @(negedge mclk);
            eventSet = 8'h00;
            @(negedge mclk);
            chk("irq", {7'h00, rows[i].irq}, {7'h00, deviceIrq});
            rd(8'hC4);
            chk("flags", rows[i].ev, sfrRdData);
            @(negedge mclk);
            chk("irq after read", 8'h00, {7'h00, deviceIrq});
            rd(8'hC4);
            chk("flags after read", 8'h00, sfrRdData);
        end
        rd(8'hC5);
        chk("mask", 8'h20, sfrRdData);
        i_cpu_sfr_model.access(1'b1, 8'hC4, 8'hFF);
        rd(8'hC4);
        chk("flags after write", 8'h00, sfrRdData);
        rd(8'h3A);
        chk("unmapped", 8'h00, sfrRdData);
        // Event raised in the very cycle the flag byte is read
        fork
            rd(8'hC4);
            begin
                @(negedge mclk);
                eventSet = 8'h04;
                @(negedge mclk);
                eventSet = 8'h00;
            end
        join
        chk("flags read with event", 8'h00, sfrRdData);
        rd(8'hC4);
        chk("event kept over clear", 8'h04, sfrRdData);
        eventSet = 8'h20;
        @(negedge mclk);
        eventSet = 8'h00;
        @(negedge mclk);
        chk("irq before second reset", 8'h01, {7'h00, deviceIrq});
        reset_n = 1'b0;
        @(negedge mclk);
        chk("irq in reset", 8'h00, {7'h00, deviceIrq});
        reset_n = 1'b1;
        rd(8'hC4);
        chk("flags second reset", 8'h00, sfrRdData);
        rd(8'hC5);
        chk("mask second reset", 8'h00, sfrRdData);
        wrap_up();
    end
endmodule

`default_nettype wire
